// ### rtl/sgc_gpio_control.v
// General-purpose pin control register and pin drivers of the switch upstream port.
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defs.vh"
module sgc_gpio_control (
  input  wire                          clk,
  input  wire                          sys_rst,
  input  wire [1:0]                    cfgPort,
  input  wire [11:0]                   cfgAddr,
  input  wire                          cfgWrite,
  input  wire                          cfgRead,
  input  wire [3:0]                    cfgByteEn,
  input  wire [31:0]                   cfgWrData,
  output reg  [31:0]                   cfgRdData,
  output reg                           cfgRdValid,
  input  wire [`SGC_DS_PORTS-1:0]      capLoad,
  input  wire [`SGC_DS_PORTS-1:0]      capLoadValue,
  input  wire [`SGC_DS_PORTS-1:0]      slotPower,
  output wire [`SGC_DS_PORTS-1:0]      localPowerEventCapability,
  input  wire [`SGC_PIN_COUNT-1:0]     gpioIn,
  output reg  [`SGC_PIN_COUNT-1:0]     gpioOut,
  output reg  [`SGC_PIN_COUNT-1:0]     gpioOe
);
  ////////////////////////////////////////////////////////////////////////////
  // Sized copies of the shared constants, so that every compare and slice
  // below works on operands of a known width.
  localparam [11:0] CTRL_OFFSET = `SGC_CTRL_OFFSET;
  localparam [1:0]  UP_PORT     = `SGC_UP_PORT;
  localparam        WORD_LSB    = `SGC_ADDR_LSB;
  localparam        BYTE_COUNT  = `SGC_BYTE_COUNT;
  localparam        FIELD_WIDTH = `SGC_FIELD_WIDTH;
  localparam [31:0] RD_IDLE     = `SGC_RD_IDLE;

  // Register state.
  reg  [`SGC_PIN_COUNT-1:0] pinDir;
  reg  [`SGC_PIN_COUNT-1:0] pinValue;
  reg  [`SGC_DS_PORTS-1:0]  capEnable;
  reg  [31:0]               next_cfgRdData;

  // Decode and next-state nets.
  wire [`SGC_PIN_COUNT-1:0] next_pinDir;
  wire [`SGC_PIN_COUNT-1:0] next_pinValue;
  wire [`SGC_PIN_COUNT-1:0] pinLevel;
  wire [`SGC_PIN_COUNT-1:0] fieldWrite;
  wire [`SGC_PIN_COUNT-1:0] next_gpioOut;
  wire [`SGC_PIN_COUNT-1:0] next_gpioOe;
  wire [BYTE_COUNT-1:0]     byteWrite;
  wire [`SGC_DS_PORTS-1:0]  next_capEnable;
  wire [31:0]               ctrlWord;
  wire                      ctrlHit;
  wire                      ctrlWrite;
  wire                      ctrlRead;
  wire                      next_cfgRdValid;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the read and write paths. The two low address
  // bits select a byte inside the word and take no part in the match.
  function ctrl_select;
    input [1:0]  port;
    input [11:0] addr;
    begin
      if (port != UP_PORT) begin
        ctrl_select = 1'h0;
      end else if (addr[11:WORD_LSB] != CTRL_OFFSET[11:WORD_LSB]) begin
        ctrl_select = 1'h0;
      end else begin
        ctrl_select = 1'h1;
      end
    end
  endfunction

  assign ctrlHit   = ctrl_select(cfgPort, cfgAddr);
  assign ctrlWrite = cfgWrite & ctrlHit;
  assign ctrlRead  = cfgRead & ctrlHit;

  // Byte lane k covers pins 2k and 2k+1, so a byte write never disturbs a
  // neighbouring pair.
  // per-byte write lanes
  genvar b;
  generate
    for (b = 0; b < BYTE_COUNT; b = b + 1) begin : gByte
      assign byteWrite[b] = ctrlWrite & cfgByteEn[b];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // The capability bits belong to the downstream ports; they are kept here
  // because they decide who owns the low pins. A load from the sideband path
  // replaces the reset default of one port without touching the other.
  genvar p;
  generate
    for (p = 0; p < `SGC_DS_PORTS; p = p + 1) begin : gCap
      assign next_capEnable[p] = capLoad[p] ? capLoadValue[p] : capEnable[p];
    end
  endgenerate

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      capEnable <= {`SGC_DS_PORTS{`SGC_CAP_RESET}};
    end else begin
      capEnable <= next_capEnable;
    end
  end

  // The capability bits are also handed out so that the downstream ports can
  // report them.
  assign localPowerEventCapability = capEnable;

  ////////////////////////////////////////////////////////////////////////////
  // One four-bit field per pin: level, direction, output value, reserved.
  genvar n;
  generate
    for (n = 0; n < `SGC_PIN_COUNT; n = n + 1) begin : gPin
      localparam IN_POS   = n * FIELD_WIDTH + `SGC_IN_BIT;
      localparam DIR_POS  = n * FIELD_WIDTH + `SGC_DIR_BIT;
      localparam OUT_POS  = n * FIELD_WIDTH + `SGC_OUT_BIT;
      localparam RSVD_POS = n * FIELD_WIDTH + `SGC_RSVD_BIT;

      // The pad level is asynchronous to the core clock. The input bit trails
      // the pin by two edges, and a read returns it one edge after that.
      // two-stage pin synchroniser
      sgc_pin_sync uSync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pinAsync (gpioIn[n]),
        .pinSync  (pinLevel[n])
      );

      assign fieldWrite[n] = byteWrite[n / `SGC_PINS_PER_BYTE];

      // A write changes the field on the edge that takes it; the pad follows
      // one edge later through the registered drivers.
      // direction bit update
      assign next_pinDir[n]   = fieldWrite[n] ? cfgWrData[DIR_POS] : pinDir[n];
      assign next_pinValue[n] = fieldWrite[n] ? cfgWrData[OUT_POS] : pinValue[n];

      assign ctrlWord[IN_POS]   = pinLevel[n];
      assign ctrlWord[DIR_POS]  = pinDir[n];
      assign ctrlWord[OUT_POS]  = pinValue[n];
      // The reserved bit is dropped on write and reads zero, so software that
      // carries it back in a read-modify-write does no harm.
      // reserved reads zero
      assign ctrlWord[RSVD_POS] = 1'h0;

      if (n < `SGC_DS_PORTS) begin : gPower
        // The value bit of a low pin only counts once its port has given up
        // the capability; until then the pin is an output of slot power.
        // value when disabled
        assign next_gpioOut[n] = capEnable[n] ? slotPower[n] : pinValue[n];
        assign next_gpioOe[n]  = capEnable[n] | pinDir[n];
      end else begin : gPlain
        assign next_gpioOut[n] = pinValue[n];
        assign next_gpioOe[n]  = pinDir[n];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Direction and value bits are held as vectors so each has one process.
  // pins start input
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinDir   <= {`SGC_PIN_COUNT{`SGC_DIR_RESET}};
      pinValue <= {`SGC_PIN_COUNT{`SGC_OUT_RESET}};
    end else begin
      pinDir   <= next_pinDir;
      pinValue <= next_pinValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers are registered so the pads see no decode glitches. A released
  // pin also has its value forced low, so that nothing but the enable decides
  // whether the pad drives.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpioOut <= {`SGC_PIN_COUNT{`SGC_OUT_RESET}};
      gpioOe  <= {`SGC_PIN_COUNT{`SGC_DIR_RESET}};
    end else begin
      gpioOut <= next_gpioOut & next_gpioOe;
      gpioOe  <= next_gpioOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // foreign reads zero
  always @* begin
    next_cfgRdData = RD_IDLE;
    if (ctrlRead) begin
      next_cfgRdData = ctrlWord;
    end
  end

  // Every read is answered, whether it hits the register or not.
  assign next_cfgRdValid = cfgRead;

  // Reads answer one cycle later. A read and a write in the same cycle return
  // the word as it stood before the write.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgRdData  <= RD_IDLE;
      cfgRdValid <= `SGC_VALID_RESET;
    end else begin
      cfgRdData  <= next_cfgRdData;
      cfgRdValid <= next_cfgRdValid;
    end
  end
endmodule // sgc_gpio_control
`default_nettype wire

// ### inc/sgc_defs.vh
// Constants of the switch general-purpose pin control block.
`ifndef SGC_DEFS_VH
`define SGC_DEFS_VH
`define SGC_PIN_COUNT     8
`define SGC_DS_PORTS      2
`define SGC_CTRL_OFFSET   12'hB8
`define SGC_UP_PORT       2'h0
`define SGC_FIELD_WIDTH   4
`define SGC_IN_BIT        0
`define SGC_DIR_BIT       1
`define SGC_OUT_BIT       2
`define SGC_IN_RESET      1'h1
`define SGC_DIR_RESET     1'h0
`define SGC_OUT_RESET     1'h0
`define SGC_CAP_RESET     1'h1
`define SGC_PINS_PER_BYTE 2
`define SGC_RSVD_BIT      3
`define SGC_ADDR_LSB      2
`define SGC_BYTE_COUNT    4
`define SGC_RD_IDLE       32'h00000000
`define SGC_VALID_RESET   1'h0
`endif

// ### rtl/sgc_pin_sync.v
// Two-stage synchroniser for one asynchronous pin level.
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defs.vh"
module sgc_pin_sync (
  input  wire clk,
  input  wire sys_rst,
  input  wire pinAsync,
  output reg  pinSync
);
  reg stageOne;

  // Both stages come up high so the input bit reads one after reset.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stageOne <= `SGC_IN_RESET;
      pinSync  <= `SGC_IN_RESET;
    end else begin
      stageOne <= pinAsync;
      pinSync  <= stageOne;
    end
  end
endmodule // sgc_pin_sync
`default_nettype wire

// ### verification/sgc_board.sv
// Board logic on the pins: drives a level wherever the switch leaves a pin released.
`timescale 1ns/1ps
`default_nettype none
module sgc_board (
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] drive,
  output wire logic [7:0] pin
);
  assign pin = (oe & out) | (~oe & drive);
endmodule // sgc_board
`default_nettype wire

// ### verification/sgc_gpio_control_assertions.sv
// Port checker of the general-purpose pin control block.
`timescale 1ns/1ps
`default_nettype none
module sgc_gpio_control_chk (
  input wire clk, sys_rst, cfgWrite, cfgRead, cfgRdValid,
  input wire [1:0] cfgPort, capLoad, capLoadValue, slotPower, localPowerEventCapability,
  input wire [11:0] cfgAddr,
  input wire [3:0] cfgByteEn,
  input wire [31:0] cfgWrData, cfgRdData,
  input wire [7:0] gpioIn, gpioOut, gpioOe
);
  wire hit = cfgPort == 2'h0 && cfgAddr[11:2] == 10'h2E;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (cfgRead |=> cfgRdValid) else $error("read unanswered");
  foreign_zero_a: assert property (cfgRead && !hit |=> cfgRdData == 32'h0) else $error("foreign read");
  reserved_zero_a: assert property (cfgRdValid |-> (cfgRdData & 32'h88888888) == 32'h0) else $error("rsvd");
  idle_low_a: assert property ((gpioOut & ~gpioOe) == 8'h0) else $error("released pin high");
  power_pin_a: assert property (localPowerEventCapability[0] |=> gpioOe[0] && gpioOut[0] == $past(slotPower[0]))
    else $error("pin0 not power");
  cap_load_a: assert property (capLoad[0] |=> localPowerEventCapability[0] == $past(capLoadValue[0]))
    else $error("cap load");
  sync_in_a: assert property (cfgRead && hit && !$past(sys_rst, 1) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
    |=> cfgRdData[20] == $past(gpioIn[5], 3)) else $error("input bit");
  dir_write_a: assert property (cfgWrite && hit && cfgByteEn[1] ##1 !cfgWrite
    |=> gpioOe[2] == $past(cfgWrData[9], 2) && gpioOut[2] == ($past(cfgWrData[9], 2) & $past(cfgWrData[10], 2)))
    else $error("pin2");
endmodule // sgc_gpio_control_chk
bind sgc_gpio_control sgc_gpio_control_chk u_chk (.*);
`default_nettype wire

// ### verification/test_switch_gpio_control.sv
// Directed bench for the general-purpose pin control block.
`timescale 1ns/1ps
`default_nettype none
module test_switch_gpio_control;
  logic clk = 0, sys_rst = 1, cfgWrite = 0, cfgRead = 0;
  logic [1:0] cfgPort = 0, capLoad = 0, capLoadValue = 0, slotPower = 2'h3;
  logic [11:0] cfgAddr = 12'hB8;
  logic [3:0] cfgByteEn = 0;
  logic [31:0] cfgWrData = 0;
  logic [7:0] drive = 8'hFF;
  wire [31:0] cfgRdData;
  wire cfgRdValid;
  wire [1:0] cap;
  wire [7:0] pin, gpioOut, gpioOe;
  int errTotal = 0, testsRun = 0;
  always #20 clk = ~clk;
  sgc_gpio_control u_dut (.*, .localPowerEventCapability(cap), .gpioIn(pin));
  sgc_board u_board (.oe(gpioOe), .out(gpioOut), .drive(drive), .pin(pin));
  task conclude;
    if (errTotal == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    #1 cfgWrite = 1;
    cfgPort = 2'h0;
    cfgAddr = 12'hB8;
    cfgWrData = d;
    cfgByteEn = be;
    @(posedge clk);
    #1 cfgWrite = 0;
    repeat (4) @(posedge clk);
  endtask
  task rd(input logic [1:0] p, input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    #1 cfgRead = 1;
    cfgPort = p;
    cfgAddr = a;
    @(posedge clk);
    #1 cfgRead = 0;
    chk({31'h0, cfgRdValid}, 32'h1);
    chk(cfgRdData, e);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 sys_rst = 0;
    repeat (4) @(posedge clk);
    rd(2'h0, 12'hB8, 32'h11111111);
    rd(2'h1, 12'hB8, 32'h0);
    rd(2'h0, 12'hB4, 32'h0);
    slotPower = 2'h1;
    drive = 8'h00;
    wr(32'hFFFFFFFF, 4'hF);
    rd(2'h0, 12'hB8, 32'h77777767);
    chk({16'h0, gpioOe, gpioOut}, 32'hFFFD);
    wr(32'h0, 4'h2);
    rd(2'h0, 12'hBB, 32'h77770067);
    @(posedge clk);
    #1 capLoad = 2'h3;
    @(posedge clk);
    #1 capLoad = 2'h0;
    repeat (2) @(posedge clk);
    #1;
    chk({14'h0, cap, gpioOe, gpioOut}, 32'hF3F3);
    wr(32'h2, 4'h1);
    #1;
    chk({16'h0, gpioOe, gpioOut}, 32'hF1F0);
    @(posedge clk);
    #1 sys_rst = 1;
    drive = 8'hFF;
    slotPower = 2'h3;
    repeat (4) @(posedge clk);
    #1 sys_rst = 0;
    chk({14'h0, cap, gpioOe, gpioOut}, 32'h30000);
    rd(2'h0, 12'hB8, 32'h11111111);
    conclude;
  end
endmodule // test_switch_gpio_control
`default_nettype wire
